/* File: design/scp_map.vh */
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
// Command codes in the first header byte, low nibble
`define SCP_CMD_W        4
`define SCP_CMD_WRITE    4'h1
`define SCP_CMD_READ     4'h3
// Header byte 0 fields: [3:0] command, [5:4] circuit, [7:6] bank
`define SCP_CKT_LSB      4
`define SCP_BANK_LSB     6
`define SCP_USER_BANK    2'h0
// Memory geometry
`define SCP_ADDR_W       8
`define SCP_MEM_DEPTH    256
`define SCP_MEM_RESET    8'h00
// Header length in bytes
`define SCP_HDR_BYTES    2'h3
`endif

/* File: design/scp_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for one pin level
module scp_sync (
  input  wire clock,
  input  wire sys_rst,
  input  wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;

  // First stage feeds only the second
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // scp_sync
`default_nettype wire

/* File: design/scp_port.v */
// How it works
// (RULE1) Slave transmits only for a read
// (RULE2) Drive output on chip select alone
// (RULE3) Master waits before collecting read data
// (RULE4) Master waits for response before next command
// (RULE5) Length field spans consecutive locations
// (RULE6) Master throttles by gaps or splits
// (RULE7) Write transfers leave output inactive
// (RULE8) Read data LSB first, ascending bytes
// (RULE9) Write frames carry data, reads don't
// (RULE10) Multibyte fields low byte first
// (RULE11) 16-bit values: low byte, then high
// (RULE12) Only bank 0 holds user settings
// (RULE13) Behaviour counts clock edges, not rate
// (RULE14) Two clocks between frames
// (RULE15) Four extra pulses after gapped write
// (RULE16) Eight extra pulses after gapped read
// (RULE17) Each location is one byte
// (RULE18) Addressed slave answers every read
// (RULE19) Master deselects after read header
// (RULE20) Response select period ignores serial input
// (RULE21) New command only after full response
// (RULE22) Memory kept across active/standby changes
// (RULE23) Non-byte select length aborts operation
// (RULE24) Byte mode: one select per byte
// (RULE25) Strap open normal, grounded byte mode
// (RULE26) Select sampled on serial clock
// (RULE27) Header: command, address, length
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.vh"
module scp_port (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       serial_bit_clock,
  input  wire       serial_in_line,
  input  wire       chip_sel_n,
  input  wire       port_mode_strap,
  output reg        serial_out_ff,
  output reg        serial_out_en_ff,
  output reg        byte_mode_ff,
  output reg        frame_error_ff
);
  localparam ST_HDR  = 2'h0;
  localparam ST_WDAT = 2'h1;
  localparam ST_RWT  = 2'h2;
  localparam ST_RDAT = 2'h3;

  wire sclk_s;
  wire din_s;
  wire csn_s;
  wire strap_s;

  // All link pins cross into the system clock domain
  scp_sync u_sync_clk (.clock(clock), .sys_rst(sys_rst), .din(serial_bit_clock), .dout(sclk_s));
  scp_sync u_sync_din (.clock(clock), .sys_rst(sys_rst), .din(serial_in_line), .dout(din_s));
  scp_sync u_sync_cs (.clock(clock), .sys_rst(sys_rst), .din(chip_sel_n), .dout(csn_s));
  scp_sync u_sync_md (.clock(clock), .sys_rst(sys_rst), .din(port_mode_strap), .dout(strap_s));

  reg        sclk_d_ff;
  reg  [1:0] state_ff;
  reg  [2:0] bit_cnt_ff;
  reg  [7:0] shift_ff;
  reg  [1:0] hdr_cnt_ff;
  reg  [7:0] cmd_ff;
  reg  [7:0] addr_ff;
  reg  [7:0] len_ff;
  reg        cs_act_ff;
  reg        abort_ff;
  reg  [7:0] mem_ff [0:`SCP_MEM_DEPTH-1];

  wire rise = sclk_s & ~sclk_d_ff;
  wire fall = ~sclk_s & sclk_d_ff;
  // Only edges matter, so a gapped clock just pauses everything
  wire samp = rise & ~csn_s;                                         // [RULE13] [RULE26]
  wire [7:0] byte_in = {din_s, shift_ff[7:1]};                       // LSB arrives first
  wire byte_done = samp & (bit_cnt_ff == 3'h7);
  wire cs_rel = rise & csn_s & cs_act_ff;
  wire is_write = (cmd_ff[`SCP_CMD_W-1:0] == `SCP_CMD_WRITE);
  wire user_bank = (cmd_ff[`SCP_BANK_LSB+1:`SCP_BANK_LSB] == `SCP_USER_BANK);
  wire [7:0] rd_byte = mem_ff[addr_ff];
  integer i;

  reg  [1:0] strap_wait_ff;

  // Mode strap follows the pin once the synchroniser holds real samples.
  // Its stages reset low, which would read as byte mode for two cycles,
  // so normal mode is shown until the pin level has come through.
  always @(posedge clock) begin
    if (sys_rst) begin
      byte_mode_ff  <= 1'b0;
      strap_wait_ff <= 2'h0;
    end else if (strap_wait_ff != 2'h3) begin
      byte_mode_ff  <= 1'b0;
      strap_wait_ff <= strap_wait_ff + 2'h1;
    end else begin
      byte_mode_ff  <= ~strap_s;                                     // [RULE25]
    end
  end

  // Edge detector reads the second stage only
  always @(posedge clock) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  // Frame engine: header, write data, read turnaround, read data
  always @(posedge clock) begin
    if (sys_rst) begin
      state_ff       <= ST_HDR;
      bit_cnt_ff     <= 3'h0;
      shift_ff       <= 8'h00;
      hdr_cnt_ff     <= 2'h0;
      cmd_ff         <= 8'h00;
      addr_ff        <= 8'h00;
      len_ff         <= 8'h00;
      cs_act_ff      <= 1'b0;
      abort_ff       <= 1'b0;
      frame_error_ff <= 1'b0;
    end else begin
      if (samp) begin
        cs_act_ff  <= 1'b1;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_ff   <= byte_in;
      end
      if (cs_rel) begin
        cs_act_ff <= 1'b0;
        // A partial byte at release kills the frame; next select restarts
        if (bit_cnt_ff != 3'h0) begin                                // [RULE23]
          state_ff       <= ST_HDR;
          hdr_cnt_ff     <= 2'h0;
          bit_cnt_ff     <= 3'h0;
          frame_error_ff <= 1'b1;
        end else if (!byte_mode_ff && state_ff == ST_WDAT) begin
          state_ff   <= ST_HDR;                                      // Write ends with select
          hdr_cnt_ff <= 2'h0;
        end else if (!byte_mode_ff && state_ff == ST_HDR && hdr_cnt_ff != 2'h0) begin
          state_ff   <= ST_HDR;                                      // Short header dropped
          hdr_cnt_ff <= 2'h0;
        end
        if (state_ff == ST_RWT && bit_cnt_ff == 3'h0) begin
          state_ff <= ST_RDAT;                                       // [RULE19] [RULE24]
        end
      end
      if (byte_done) begin
        frame_error_ff <= 1'b0;
        case (state_ff)
          ST_HDR: begin
            case (hdr_cnt_ff)                                        // [RULE27]
              2'h0: cmd_ff <= byte_in;
              2'h1: addr_ff <= byte_in;
              default: len_ff <= byte_in;
            endcase
            if (hdr_cnt_ff == `SCP_HDR_BYTES - 2'h1) begin
              hdr_cnt_ff <= 2'h0;
              if (byte_in == 8'h00) begin
                state_ff <= ST_HDR;
              end else if (is_write) begin
                state_ff <= ST_WDAT;                                 // [RULE9]
              end else if (cmd_ff[`SCP_CMD_W-1:0] == `SCP_CMD_READ) begin
                state_ff <= ST_RWT;                                  // [RULE18]
              end
            end else begin
              hdr_cnt_ff <= hdr_cnt_ff + 2'h1;
            end
          end
          ST_WDAT: begin
            addr_ff <= addr_ff + 8'h01;                              // [RULE5] [RULE10] [RULE11]
            len_ff  <= len_ff - 8'h01;
            if (len_ff == 8'h01) begin
              state_ff <= ST_HDR;
            end
          end
          ST_RDAT: begin
            addr_ff <= addr_ff + 8'h01;                              // [RULE8]
            len_ff  <= len_ff - 8'h01;
            if (len_ff == 8'h01) begin
              state_ff <= ST_HDR;                                    // [RULE21]
            end
          end
          default: begin
            state_ff <= state_ff;
          end
        endcase
      end
    end
  end

  // Control memory, one byte per location, only reset clears it.
  // Only user bank writes land: the other banks hold internal state,
  // so a stray write there is dropped rather than corrupting it.
  // Limitation: reads of any bank return the shared storage.
  always @(posedge clock) begin
    if (sys_rst) begin
      for (i = 0; i < `SCP_MEM_DEPTH; i = i + 1) begin
        mem_ff[i] <= `SCP_MEM_RESET;
      end
    end else if (byte_done && state_ff == ST_WDAT && is_write && user_bank) begin
      mem_ff[addr_ff] <= byte_in;                                    // [RULE17] [RULE12] [RULE22]
    end
  end

  // Output driver: response window only, no bus sensing
  always @(posedge clock) begin
    if (sys_rst) begin
      serial_out_ff    <= 1'b0;
      serial_out_en_ff <= 1'b0;
    end else begin
      // Select gates the driver in ST_RDAT only; the master keeps others off the line
      serial_out_en_ff <= (state_ff == ST_RDAT) & ~csn_s;            // [RULE1] [RULE2] [RULE7] [RULE20]
      if (fall || !cs_act_ff) begin
        serial_out_ff <= rd_byte[bit_cnt_ff];                        // [RULE8]
      end
    end
  end
endmodule // scp_port
`default_nettype wire

/* File: verif/scp_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin checks; bounds leave room for the input synchroniser delay
module scp_port_sva (
  input wire clock,
  input wire sys_rst,
  input wire serial_bit_clock,
  input wire serial_in_line,
  input wire chip_sel_n,
  input wire port_mode_strap,
  input wire serial_out_ff,
  input wire serial_out_en_ff,
  input wire byte_mode_ff,
  input wire frame_error_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_sel; $rose(serial_out_en_ff) |-> !chip_sel_n && !$past(chip_sel_n, 2); endproperty
  a_sel: assert property (p_sel) else $error("drive while unselected");
  property p_rel; $rose(chip_sel_n) |-> ##[0:40] !serial_out_en_ff; endproperty
  a_rel: assert property (p_rel) else $error("drive after release");
  property p_rst; disable iff (1'b0) sys_rst |=> !serial_out_en_ff && !frame_error_ff && !byte_mode_ff; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_nrm; port_mode_strap [*8] |=> !byte_mode_ff; endproperty
  a_nrm: assert property (p_nrm) else $error("normal mode");
  property p_byt; !port_mode_strap [*8] |=> byte_mode_ff; endproperty
  a_byt: assert property (p_byt) else $error("byte mode");
  property p_hold; serial_out_en_ff && $changed(serial_out_ff) |=> (!serial_out_en_ff || $stable(serial_out_ff)) [*3]; endproperty
  a_hold: assert property (p_hold) else $error("data bit too short");
  property p_err; $rose(frame_error_ff) |-> chip_sel_n && $past(chip_sel_n, 3); endproperty
  a_err: assert property (p_err) else $error("error while selected");
  property p_wid; $rose(serial_out_en_ff) |=> serial_out_en_ff [*8]; endproperty
  a_wid: assert property (p_wid) else $error("enable too short");
endmodule // scp_port_sva
bind scp_port scp_port_sva scp_port_sva_inst (.clock(clock), .sys_rst(sys_rst), .serial_bit_clock(serial_bit_clock),
  .serial_in_line(serial_in_line), .chip_sel_n(chip_sel_n), .port_mode_strap(port_mode_strap),
  .serial_out_ff(serial_out_ff), .serial_out_en_ff(serial_out_en_ff), .byte_mode_ff(byte_mode_ff),
  .frame_error_ff(frame_error_ff));
`default_nettype wire

/* File: verif/scp_mst.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial master; idle data toggles so a stale level never looks valid
module scp_mst (
  input  wire  clock,
  output logic sclk = 1'b1,
  output logic sdi  = 1'b0,
  output logic cs_n = 1'b1
);
  // One bit per eight clocks, well above the edge spacing limit
  task automatic bit1(input logic b);
    @(negedge clock);
    sdi = b;
    sclk = 1'b0;
    repeat (4) @(negedge clock);
    sclk = 1'b1;
    repeat (3) @(negedge clock);
  endtask
  // Select change with settle time so the slave sees it before the next bit
  task automatic sel(input logic v);
    @(negedge clock);
    cs_n = v;
    repeat (8) @(negedge clock);
  endtask
  // Byte LSB first; byte mode selects each byte alone
  task automatic byt(input logic [7:0] d, input logic bm);
    if (bm) sel(1'b0);
    for (int i = 0; i < 8; i++) bit1(d[i]);
    if (bm) sel(1'b1);
    if (bm) bit1(~sdi);
  endtask
endmodule // scp_mst
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.vh"
module tb_top;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       port_mode_strap = 1'b1;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  logic [7:0] got = 8'h00;
  int         nb = 0;
  int         bad_count = 0;
  int         checks_done = 0;
  wire        sclk, sdi, cs_n, sout, sen, bmode, ferr;
  always #20 clock = ~clock;
  scp_port scp_port_inst (.clock(clock), .sys_rst(sys_rst), .serial_bit_clock(sclk), .serial_in_line(sdi),
    .chip_sel_n(cs_n), .port_mode_strap(port_mode_strap), .serial_out_ff(sout), .serial_out_en_ff(sen),
    .byte_mode_ff(bmode), .frame_error_ff(ferr));
  scp_mst scp_mst_inst (.clock(clock), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Gather response bytes; a byte nobody asked for is a mismatch
  always @(posedge sclk) begin
    if (!cs_n && sen === 1'b1) begin
      got = {sout, got[7:1]};
      nb = (nb + 1) % 8;
      if (nb == 0) chk("read", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, got);
    end
  end
  // One command; response data drives noise on the input line
  task automatic cmd(input logic is_rd, input logic [7:0] a, input int n, input logic bm);
    logic [7:0] d;
    if (!bm) scp_mst_inst.sel(1'b0);
    scp_mst_inst.byt({`SCP_USER_BANK, 2'h0, is_rd ? `SCP_CMD_READ : `SCP_CMD_WRITE}, bm);
    scp_mst_inst.byt(a, bm);
    scp_mst_inst.byt(8'(n), bm);
    if (is_rd) scp_mst_inst.sel(1'b1);
    if (is_rd) repeat (10) scp_mst_inst.bit1(~sdi);
    for (int i = 0; i < n; i++) begin
      d = is_rd ? mem[8'(a + i)] : 8'($urandom);
      mem[8'(a + i)] = d;
      if (is_rd) exp_q.push_back(d);
      if (is_rd && !bm && i == 0) scp_mst_inst.sel(1'b0);
      scp_mst_inst.byt(is_rd ? 8'($urandom) : d, bm);
    end
    scp_mst_inst.sel(1'b1);
    repeat (8) scp_mst_inst.bit1(~sdi);
  endtask
  initial begin
    void'($urandom(32'h63ED));
    foreach (mem[i]) mem[i] = `SCP_MEM_RESET;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 2; k++) begin
      // Mid-run reset clears the control memory and the error flag
      if (k == 1) begin
        sys_rst = 1'b1;
        repeat (20) @(negedge clock);
        foreach (mem[i]) mem[i] = `SCP_MEM_RESET;
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        chk("rst", 8'h00, {6'h00, ferr, sen});
      end
      port_mode_strap = (k == 0);
      repeat (12) @(negedge clock);
      chk("mode", 8'(k), {7'h00, bmode});
      cmd(1'b0, 8'hFD, 3, 1'(k));
      cmd(1'b1, 8'hFD, 3, 1'(k));
      cmd(1'b1, 8'hF0, 1, 1'(k));
      // Five-bit select aborts; the next select starts afresh
      scp_mst_inst.sel(1'b0);
      repeat (5) scp_mst_inst.bit1(1'($urandom));
      scp_mst_inst.sel(1'b1);
      repeat (2) scp_mst_inst.bit1(~sdi);
      chk("abort", 8'h01, {7'h00, ferr});
      cmd(1'b0, 8'h20, 1, 1'(k));
      cmd(1'b1, 8'h1F, 2, 1'(k));
    end
    chk("left", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
  // Whole run takes well under a millisecond
  initial begin
    #2000000;
    bad_count++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
